// ==== hw/spi_nvsram_host.sv ====
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spi_nvsram_host #(
    parameter int RESTORE_NS  = 100000,
    parameter int RESTORE_CYC = (RESTORE_NS + spi_host_pkg::CLK_NS - 1)
                                / spi_host_pkg::CLK_NS,
    parameter int CNT_W       = 20
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write channels
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read channels
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial memory pins
    output logic             spi_sck,
    output logic             spi_cs_n,
    output logic             spi_mosi,
    input  wire logic        spi_miso,
    output logic             spi_hold_n,
    output logic             spi_wp_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spi_host_pkg::state_e state_r;
    spi_host_pkg::cmd_s   cmd_w;
    logic [CNT_W-1:0]     tmr_r;
    logic [7:0]           div_r;
    logic [4:0]           bits_r;
    logic [15:0]          tx_r;
    logic [7:0]           rx_r;
    logic [7:0]           op_r;
    logic [1:0]           cfg_r;
    logic                 wel_r;
    logic                 hib_r;
    logic                 err_r;
    logic                 miso_s1_r;
    logic                 miso_s2_r;

    logic wr_take;
    logic rd_take;
    logic cmd_wr;
    logic stat_wr;
    logic write_type;
    logic launch;
    logic refuse;
    logic tick;
    logic run;
    logic hold_enter;
    logic hold_leave;
    logic sck_rise;
    logic sck_fall;
    logic last_fall;
    logic gap_done;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // handshake edges: ready flops are high exactly one cycle
    assign wr_take = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    assign rd_take = s_axi_arready & s_axi_arvalid;
    assign cmd_w   = s_axi_wdata[$bits(spi_host_pkg::cmd_s)-1:0];
    assign cmd_wr  = wr_take & (s_axi_awaddr == spi_host_pkg::REG_CMD)
                     & (&s_axi_wstrb[2:0]);
    assign stat_wr = wr_take & (s_axi_awaddr == spi_host_pkg::REG_STAT)
                     & s_axi_wstrb[0];

    // write-type opcodes are guarded by the latch shadow
    always_comb begin
        case (cmd_w.op)
            spi_host_pkg::OP_WRITE_STATUS,
            spi_host_pkg::OP_WRITE,
            spi_host_pkg::OP_SECURE_WRITE,
            spi_host_pkg::OP_WRITE_SERIAL: write_type = 1'b1;
            default:                       write_type = 1'b0;
        endcase
    end

    // commands while busy are dropped; an unset latch refuses writes
    assign refuse = cmd_wr & (state_r == spi_host_pkg::ST_IDLE)
                    & write_type & ~wel_r;
    assign launch = cmd_wr & (state_r == spi_host_pkg::ST_IDLE) & ~refuse;

    // ------------------------------------------------------------
    // serial clock timing
    // ------------------------------------------------------------
    assign tick       = (state_r == spi_host_pkg::ST_SHIFT)
                        & (div_r == 8'(spi_host_pkg::SCK_HALF_CYC - 1));
    // hold only ever starts or ends while the clock rests low
    assign hold_enter = tick & ~spi_sck & spi_hold_n & cfg_r[spi_host_pkg::CFG_HOLD];
    assign hold_leave = tick & ~spi_sck & ~spi_hold_n
                        & ~cfg_r[spi_host_pkg::CFG_HOLD];
    assign run        = tick & spi_hold_n & ~hold_enter;
    assign sck_rise   = run & ~spi_sck;
    assign sck_fall   = run & spi_sck;
    assign last_fall  = sck_fall & (bits_r == 5'h1);
    assign gap_done   = (state_r == spi_host_pkg::ST_GAP) & (tmr_r == '0);

    // half-period divider, restarts with every transfer
    always_ff @(posedge aclk) begin
        if (!aresetn || state_r != spi_host_pkg::ST_SHIFT || tick) begin
            div_r <= 8'h0;
        end else begin
            div_r <= div_r + 8'h1;
        end
    end

    // miso comes from another chip: two flops before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= spi_miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    // reset lands in the gap so chip enable is seen high first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= spi_host_pkg::ST_GAP;
            tmr_r   <= CNT_W'(spi_host_pkg::CS_HIGH_CYC);
        end else begin
            case (state_r)
                spi_host_pkg::ST_IDLE: begin
                    if (launch && hib_r) begin
                        state_r <= spi_host_pkg::ST_WAKE;
                        tmr_r   <= CNT_W'(RESTORE_CYC);
                    end else if (launch) begin
                        state_r <= spi_host_pkg::ST_SHIFT;
                    end
                end
                spi_host_pkg::ST_WAKE: begin
                    // no clocks until the restore time has passed
                    if (tmr_r == '0) begin
                        state_r <= spi_host_pkg::ST_SHIFT;
                    end else begin
                        tmr_r <= tmr_r - CNT_W'(1);
                    end
                end
                spi_host_pkg::ST_SHIFT: begin
                    if (last_fall) begin
                        state_r <= spi_host_pkg::ST_GAP;
                        tmr_r   <= CNT_W'(spi_host_pkg::CS_HIGH_CYC);
                    end
                end
                spi_host_pkg::ST_GAP: begin
                    if (gap_done) begin
                        state_r <= spi_host_pkg::ST_IDLE;
                    end else begin
                        tmr_r <= tmr_r - CNT_W'(1);
                    end
                end
                default: begin
                    state_r <= spi_host_pkg::ST_GAP;
                    tmr_r   <= CNT_W'(spi_host_pkg::CS_HIGH_CYC);
                end
            endcase
        end
    end

    // chip enable falls at launch, rises only after the last bit;
    // it stays low through a hold so the operation survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spi_cs_n <= 1'b1;
        end else if (launch) begin
            spi_cs_n <= 1'b0;
        end else if (last_fall) begin
            spi_cs_n <= 1'b1;
        end
    end

    // mode 0: clock idles low, rising samples, falling shifts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spi_sck <= 1'b0;
        end else if (sck_rise) begin
            spi_sck <= 1'b1;
        end else if (sck_fall) begin
            spi_sck <= 1'b0;
        end
    end

    // hold is requested by software, applied between bits only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spi_hold_n <= 1'b1;
        end else if (hold_enter) begin
            spi_hold_n <= 1'b0;
        end else if (hold_leave) begin
            spi_hold_n <= 1'b1;
        end
    end

    // bit counter: opcode alone, or opcode and one data byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bits_r <= 5'h0;
        end else if (launch && (cmd_w.wd || cmd_w.rd)) begin
            bits_r <= 5'(spi_host_pkg::BITS_DATA);
        end else if (launch) begin
            bits_r <= 5'(spi_host_pkg::BITS_OP);
        end else if (sck_fall) begin
            bits_r <= bits_r - 5'h1;
        end
    end

    // outgoing shifter, msb first; next bit set up on falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_r     <= 16'h0;
            spi_mosi <= 1'b0;
            op_r     <= 8'h0;
        end else if (launch) begin
            tx_r     <= {cmd_w.op, cmd_w.data};
            spi_mosi <= cmd_w.op[7];
            op_r     <= cmd_w.op;
        end else if (sck_fall) begin
            tx_r     <= {tx_r[14:0], 1'b0};
            spi_mosi <= tx_r[14];
        end
    end

    // incoming shifter; the late edge of the high phase keeps the
    // sync delay inside the half period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_r <= 8'h0;
        end else if (sck_fall) begin
            rx_r <= {rx_r[6:0], miso_s2_r};
        end
    end

    // ------------------------------------------------------------
    // latch shadow, hibernate and error flags
    // ------------------------------------------------------------
    // the shadow follows what the device latch does on completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wel_r <= 1'b0;
        end else if (last_fall) begin
            case (op_r)
                spi_host_pkg::OP_SET_WRITE_LATCH: wel_r <= 1'b1;
                spi_host_pkg::OP_CLR_WRITE_LATCH: wel_r <= 1'b0;
                spi_host_pkg::OP_WRITE_STATUS,
                spi_host_pkg::OP_WRITE,
                spi_host_pkg::OP_SECURE_WRITE,
                spi_host_pkg::OP_WRITE_SERIAL:    wel_r <= 1'b0;
                default:                          wel_r <= wel_r;
            endcase
        end
    end

    // hibernate starts at the deselect after its opcode and ends
    // when the restore wait after the next selection runs out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hib_r <= 1'b0;
        end else if (last_fall && op_r == spi_host_pkg::OP_HIBERNATE) begin
            hib_r <= 1'b1;
        end else if (state_r == spi_host_pkg::ST_WAKE && tmr_r == '0) begin
            hib_r <= 1'b0;
        end
    end

    // refused write command; a new refusal beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_r <= 1'b0;
        end else if (refuse) begin
            err_r <= 1'b1;
        end else if (stat_wr && s_axi_wdata[spi_host_pkg::STAT_ERR]) begin
            err_r <= 1'b0;
        end
    end

    // configuration: hold request and write protect level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= spi_host_pkg::CFG_RESET;
        end else if (wr_take && s_axi_awaddr == spi_host_pkg::REG_CFG
                     && s_axi_wstrb[0]) begin
            cfg_r <= s_axi_wdata[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spi_wp_n <= 1'b1;
        end else begin
            spi_wp_n <= cfg_r[spi_host_pkg::CFG_WP_N];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    // both channels are taken together, one write in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                             & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                             & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= spi_host_pkg::RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr == spi_host_pkg::REG_CMD
                || s_axi_awaddr == spi_host_pkg::REG_STAT
                || s_axi_awaddr == spi_host_pkg::REG_CFG) begin
                s_axi_bresp <= spi_host_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= spi_host_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
        end
    end

    // status shows busy, latch shadow, hibernate, error, last byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= spi_host_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= spi_host_pkg::RESP_OKAY;
            case (s_axi_araddr)
                spi_host_pkg::REG_STAT: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rdata[spi_host_pkg::STAT_BUSY] <=
                        (state_r != spi_host_pkg::ST_IDLE);
                    s_axi_rdata[spi_host_pkg::STAT_WEL] <= wel_r;
                    s_axi_rdata[spi_host_pkg::STAT_HIB] <= hib_r;
                    s_axi_rdata[spi_host_pkg::STAT_ERR] <= err_r;
                    s_axi_rdata[spi_host_pkg::STAT_RX +: 8] <= rx_r;
                end
                spi_host_pkg::REG_CFG: begin
                    s_axi_rdata <= {30'h0, cfg_r};
                end
                spi_host_pkg::REG_CMD: begin
                    s_axi_rdata <= {24'h0, op_r};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= spi_host_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // spi_nvsram_host

// ==== pkg/spi_host_pkg.sv ====
package spi_host_pkg;

    // ------------------------------------------------------------
    // device instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_READ_STATUS     = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS    = 8'h01;
    localparam logic [7:0] OP_READ            = 8'h03;
    localparam logic [7:0] OP_SECURE_READ     = 8'h13;
    localparam logic [7:0] OP_WRITE           = 8'h02;
    localparam logic [7:0] OP_SECURE_WRITE    = 8'h12;
    localparam logic [7:0] OP_STORE           = 8'h08;
    localparam logic [7:0] OP_RECALL          = 8'h09;
    localparam logic [7:0] OP_WRITE_SERIAL    = 8'hc2;
    localparam logic [7:0] OP_READ_SERIAL     = 8'hc3;
    localparam logic [7:0] OP_HIBERNATE       = 8'hb9;

    // ------------------------------------------------------------
    // device status byte layout
    // ------------------------------------------------------------
    localparam int SR_HW_PROTECT_ENABLE = 7;
    localparam int SR_UNUSED            = 6;
    localparam int SR_ROLLOVER_SELECT   = 5;
    localparam int SR_CRC_WRITE_FAIL    = 4;
    localparam int SR_PROTECT_LEVEL_HI  = 3;
    localparam int SR_PROTECT_LEVEL_LO  = 2;
    localparam int SR_WRITE_LATCH       = 1;
    localparam int SR_NV_BUSY           = 0;

    // ------------------------------------------------------------
    // host register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CMD  = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_CFG  = 4'h8;

    localparam int STAT_BUSY = 0;
    localparam int STAT_WEL  = 1;
    localparam int STAT_HIB  = 2;
    localparam int STAT_ERR  = 3;
    localparam int STAT_RX   = 8;
    localparam int CFG_HOLD  = 0;
    localparam int CFG_WP_N  = 1;

    localparam logic [1:0] CFG_RESET   = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS      = 10;
    localparam int SCK_HALF_NS = 40;
    localparam int CS_HIGH_NS  = 40;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_HIGH_CYC  = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int BITS_OP   = 8;
    localparam int BITS_DATA = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wd;
        logic [7:0] data;
        logic [7:0] op;
    } cmd_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_WAKE  = 2'h1,
        ST_SHIFT = 2'h3,
        ST_GAP   = 2'h2
    } state_e;

endpackage

// ==== verification/nvsram_device_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// behavioural serial memory device
// ----------------------------------------
module nvsram_device_model #(
    parameter int RESTORE_NS = 200,
    parameter int BUSY_NS    = 2000
) (
    // serial pins
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      miso
);
    logic [7:0] sr, sh, op, last_op;
    logic       hib, held, viol, drv, obit, junk;
    int         nbits;
    time        t_sel;

    // latch starts clear; nonvolatile bits start at zero here
    initial begin
        {sr, sh, last_op} = '0;
        {hib, held, viol, drv, obit, junk} = '0;
        op = 8'hff;
        nbits = 0;
        t_sel = 0;
    end

    // a released line must not look like a clean level
    always #7 junk = ~junk;
    assign miso = (drv && !cs_n && !held) ? obit : junk;

    // selection starts a fresh instruction
    always @(negedge cs_n) begin
        nbits = 0;
        op = 8'hff;
        drv = 1'b0;
        t_sel = $time;
    end

    // hold only follows hold_n while selected with sck low; wp_n plays no part
    always @(hold_n) if (!cs_n && !sck) held = !hold_n;

    // shift in msb first on rising sck
    always @(posedge sck) begin
        if (!cs_n && !held) begin
            if (hib && $time - t_sel < RESTORE_NS) viol = 1'b1;
            sh = {sh[6:0], mosi};
            nbits++;
            if (nbits == 8) op = sh;
            if (nbits == 8) last_op = sh;
        end
    end

    // only the status read drives data, after falling sck
    always @(negedge sck) begin
        if (!cs_n && !held && op == 8'h05 && nbits >= 8 && nbits < 16) begin
            obit = sr[15 - nbits];
            drv = 1'b1;
        end
    end

    // instructions take effect at deselect
    always @(posedge cs_n) begin
        held = 1'b0;
        if (nbits == 8 && op == 8'h06) sr[1] = 1'b1;
        if (nbits == 8 && op == 8'h04) sr[1] = 1'b0;
        if (op == 8'h01 && sr[1] && nbits == 16)
            sr = {sh[7], 1'b0, sh[5], sr[4], sh[3:2], sr[1:0]};
        if (op inside {8'h01, 8'h02, 8'h12, 8'hc2}) sr[1] = 1'b0;
        hib = nbits == 8 && op == 8'hb9;
        if (nbits == 8 && op inside {8'h08, 8'h09}) begin
            sr[0] = 1'b1;
            fork
                #(BUSY_NS) sr[0] = 1'b0;
            join_none
        end
    end
endmodule // nvsram_device_model

// ==== verification/spi_nvsram_host_assertions.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// serial pin checks
// ----------------------------------------
module spi_nvsram_host_assertions (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // serial pins
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_hold_n
);
    logic [5:0] bits_r;
    logic       sck_q_r;

    // rising sck count per frame, so a cut byte shows up at deselect
    always_ff @(posedge aclk) begin
        sck_q_r <= spi_sck;
        if (!aresetn || spi_cs_n) bits_r <= 6'h00;
        else if (spi_sck && !sck_q_r) bits_r <= bits_r + 6'h01;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sck_idle_low: assert property (spi_cs_n |-> !spi_sck)
        else $error("sck high while deselected");
    a_mosi_steady: assert property (spi_sck |-> $stable(spi_mosi))
        else $error("mosi moved while sck high");
    a_sck_high_width: assert property ($rose(spi_sck) |-> spi_sck [*4] ##1 !spi_sck)
        else $error("sck high phase not 4 cycles");
    a_hold_at_low: assert property ($fell(spi_hold_n) |-> !spi_sck && !spi_cs_n)
        else $error("hold entered with sck high");
    a_hold_release: assert property ($rose(spi_hold_n) && $past(aresetn) |->
        !spi_sck && !spi_cs_n)
        else $error("hold left with sck high");
    a_hold_keeps_cs: assert property (!spi_hold_n |-> !spi_cs_n)
        else $error("deselect during hold");
    a_cs_gap: assert property ($rose(spi_cs_n) |-> spi_cs_n [*5])
        else $error("deselect gap too short");
    a_frame_bytes: assert property ($rose(spi_cs_n) && $past(aresetn) |->
        bits_r == 6'h08 || bits_r == 6'h10)
        else $error("frame not whole bytes");
endmodule // spi_nvsram_host_assertions

bind spi_nvsram_host spi_nvsram_host_assertions u_spi_nvsram_host_assertions (
    .aclk(aclk), .aresetn(aresetn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n));

// ==== verification/spi_nvsram_host_test.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// register level tests of the host
// ----------------------------------------
module spi_nvsram_host_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        sck, cs_n, mosi, miso, hold_n, wp_n;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    int          mismatches, tests_run;
    logic [7:0]  ops [12] = '{8'h05, 8'h01, 8'h03, 8'h13, 8'h02, 8'h12,
                              8'h08, 8'h09, 8'hc2, 8'hc3, 8'h06, 8'h04};

    spi_nvsram_host #(.RESTORE_CYC(20)) u_spi_nvsram_host (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .spi_hold_n(hold_n), .spi_wp_n(wp_n));

    nvsram_device_model #(.RESTORE_NS(200)) u_nvsram_device_model (
        .sck(sck), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n), .miso(miso));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped at its own ready
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            aw_done = aw_done | (awready === 1'b1);
            w_done = w_done | (wready === 1'b1);
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end while (!(aw_done && w_done));
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // polling is bounded at 500 reads; a host that never goes idle counts a mismatch
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            axi_rd(4'h4);
            n++;
        end while (d[0] !== 1'b0 && n < 500);
        if (d[0] !== 1'b0) mismatches++;
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] v, input logic [1:0] fl);
        axi_wr(4'h0, {14'h0000, fl, v, op});
        wait_idle;
    endtask

    task automatic rd_byte(input logic [7:0] e);
        cmd(8'h05, 8'h00, 2'h2);
        check({24'h0, d[15:8]}, {24'h0, e});
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hang must still end in a verdict
    initial begin
        #400000;
        mismatches++;
        give_verdict;
    end

    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(4'h8);
        check(d, 32'h2);
        axi_rd(4'hc);
        check({30'h0, r}, 32'h2);
        axi_wr(4'hc, 32'h0);
        check({30'h0, r}, 32'h2);
        wait_idle;
        cmd(8'h02, 8'h00, 2'h1);
        axi_rd(4'h4);
        check(d & 32'ha, 32'h8);
        check({24'h0, u_nvsram_device_model.last_op}, 32'h0);
        axi_wr(4'h4, 32'h8);
        check({30'h0, r}, 32'h0);
        cmd(8'h06, 8'h00, 2'h0);
        check({24'h0, u_nvsram_device_model.sr}, 32'h2);
        rd_byte(8'h02);
        cmd(8'h01, 8'hec, 2'h1);
        rd_byte(8'hac);
        axi_wr(4'h8, 32'h0);
        cmd(8'h06, 8'h00, 2'h0);
        cmd(8'h04, 8'h00, 2'h0);
        check({31'h0, wp_n}, 32'h0);
        rd_byte(8'hac);
        axi_wr(4'h8, 32'h2);
        cmd(8'h08, 8'h00, 2'h0);
        rd_byte(8'had);
        for (int i = 0; i < 12; i++) begin
            cmd(8'h06, 8'h00, 2'h0);
            cmd(ops[i], 8'h00, 2'h0);
            check({24'h0, u_nvsram_device_model.last_op}, {24'h0, ops[i]});
        end
        cmd(8'hb9, 8'h00, 2'h0);
        check(d & 32'h4, 32'h4);
        rd_byte(8'hac);
        check({31'h0, u_nvsram_device_model.viol}, 32'h0);
        check(d & 32'h4, 32'h0);
        // suspend a status read midway, then let it finish
        axi_wr(4'h0, 32'h00020005);
        axi_wr(4'h8, 32'h3);
        repeat (40) @(posedge aclk);
        check({29'h0, cs_n, hold_n, sck}, 32'h0);
        axi_wr(4'h8, 32'h2);
        wait_idle;
        check({24'h0, d[15:8]}, 32'hac);
        axi_rd(4'h0);
        check(d, 32'h5);
        give_verdict;
    end
endmodule // spi_nvsram_host_test
